/* core/decoder_pkg.sv */
// Shared types and constants for the instruction format decoder
package decoder_pkg;
    // Word widths
    localparam int WORD_W = 24;
    localparam int OPC_W = 8;
    localparam int OPND_W = 16;
    localparam int OPC_LSB = 16;
    localparam int ADDR_HI_W = 7;
    // Opcode ranges of the instruction groups (lower bound of each, upper bound where named HI)
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_BRA = 8'h01;
    localparam logic [7:0] OPC_BRA_COMPUTED = 8'h02;
    localparam logic [7:0] OPC_INDIRECT = 8'h03;
    localparam logic [7:0] OPC_TABLE_LO = 8'h04;
    localparam logic [7:0] OPC_TABLE_HI = 8'h07;
    localparam logic [7:0] OPC_RETURN = 8'h08;
    localparam logic [7:0] OPC_RET_INT = 8'h09;
    localparam logic [7:0] OPC_COND_LO = 8'h0a;
    localparam logic [7:0] OPC_COND_HI = 8'h0b;
    localparam logic [7:0] OPC_SKIP = 8'h0c;
    localparam logic [7:0] OPC_DOUBLE_LO = 8'h0d;
    localparam logic [7:0] OPC_DOUBLE_HI = 8'h0f;
    localparam logic [7:0] OPC_WORKING_REGISTER_ZERO_LO = 8'h10;
    localparam logic [7:0] OPC_FILE_LO = 8'h40;
    localparam logic [7:0] OPC_BIT_LO = 8'h60;
    localparam logic [7:0] OPC_LITMOV_LO = 8'h80;
    localparam logic [7:0] OPC_LITALU_LO = 8'ha0;
    localparam logic [7:0] OPC_MAC_LO = 8'hc0;
    localparam logic [7:0] OPC_DSP_LO = 8'he0;
    // Extra no-operation slots per instruction kind, then total cycle counts
    localparam logic [1:0] EXTRA_NONE = 2'h0;
    localparam logic [1:0] EXTRA_BRANCH = 2'h1;
    localparam logic [1:0] EXTRA_TABLE = 2'h2;
    localparam logic [1:0] EXTRA_RETURN = 2'h2;
    localparam logic [1:0] EXTRA_TAKEN = 2'h1;
    localparam logic [1:0] CYCLES_ONE = 2'h1;
    localparam logic [1:0] CYCLES_DOUBLE = 2'h2;

    // Instruction groups
    typedef enum logic [2:0] {
        GRP_NOP = 3'b000,
        GRP_WORD_BYTE = 3'b001,
        GRP_BIT = 3'b010,
        GRP_LITERAL = 3'b011,
        GRP_DSP = 3'b100,
        GRP_CONTROL = 3'b101
    } group_e;

    // Decoded operand fields, overlapped across groups
    typedef struct packed {
        group_e group;
        logic [7:0] opcode;
        logic file_form;          // File register form
        logic mac_form;           // Multiplying signal-processing form
        logic [3:0] base_source_register;
        logic [3:0] second_source_register;
        logic [1:0] src_mode;     // Address modifier of the second source
        logic [3:0] result_destination_register;
        logic [1:0] dst_mode;     // Address modifier of the destination
        logic has_dst;            // Separate destination present
        logic [12:0] file_addr;
        logic to_working_register_zero;
        logic [3:0] bit_pos;
        logic bit_from_base;      // Bit number taken from the base register
        logic [15:0] literal;
        logic acc_b;              // Accumulator B selected
        logic [2:0] mult_pair;
        logic [3:0] x_prefetch;
        logic [3:0] y_prefetch;
        logic [1:0] x_dest;
        logic [1:0] y_dest;
        logic acc_writeback;
        logic shift_from_reg;     // Shift amount from shift_amount_register
        logic [3:0] shift_amount_register;
        logic [22:0] prog_addr;
        logic [1:0] table_mode;
    } decoded_s;
endpackage : decoder_pkg

/* core/decode_if.sv */
// Carrier between the word splitter and the sequencing logic
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
    import decoder_pkg::*;
    logic [WORD_W-1:0] word;  // Program word to split
    decoded_s fields;         // Split operand fields
    modport producer (input word, output fields);
    modport consumer (output word, input fields);
endinterface : decode_if
`default_nettype wire

/* core/field_extract.sv */
// Splits one program word into opcode, group and operand fields
`timescale 1ns/1ps
`default_nettype none
module field_extract (
    decode_if.producer bus
);
    import decoder_pkg::*;

    logic [7:0] opc;
    logic [15:0] op;
    assign opc = bus.word[WORD_W-1:OPC_LSB];
    assign op = bus.word[OPND_W-1:0];

    // Group by opcode range, then overlay fields
    always_comb begin
        bus.fields = '0;
        bus.fields.opcode = opc;
        bus.fields.literal = op;
        if (opc == OPC_NOP) begin
            bus.fields.group = GRP_NOP;
        end else if (opc < OPC_WORKING_REGISTER_ZERO_LO) begin
            bus.fields.group = GRP_CONTROL;
            bus.fields.prog_addr = {7'h00, op};
            bus.fields.table_mode = op[15:14];
            bus.fields.second_source_register = op[3:0];
        end else if (opc < OPC_FILE_LO) begin
            bus.fields.group = GRP_WORD_BYTE;
            bus.fields.base_source_register = op[15:12];
            bus.fields.src_mode = op[11:10];
            bus.fields.second_source_register = op[9:6];
            bus.fields.dst_mode = op[5:4];
            bus.fields.result_destination_register = op[3:0];
            bus.fields.has_dst = 1'b1;
        end else if (opc < OPC_BIT_LO) begin
            bus.fields.group = GRP_WORD_BYTE;
            bus.fields.file_form = 1'b1;
            bus.fields.file_addr = op[12:0];
            bus.fields.to_working_register_zero = op[13];
        end else if (opc < OPC_LITMOV_LO) begin
            bus.fields.group = GRP_BIT;
            bus.fields.file_form = op[15];
            bus.fields.file_addr = op[12:0];
            bus.fields.second_source_register = op[3:0];
            bus.fields.src_mode = op[5:4];
            bus.fields.bit_from_base = op[14];
            bus.fields.base_source_register = op[9:6];
            bus.fields.bit_pos = op[9:6];
        end else if (opc < OPC_LITALU_LO) begin
            bus.fields.group = GRP_LITERAL;
            bus.fields.file_form = opc[4];
            bus.fields.file_addr = {opc[3:0], op[15:7]};
            bus.fields.result_destination_register = opc[3:0];
            bus.fields.has_dst = 1'b1;
        end else if (opc < OPC_MAC_LO) begin
            bus.fields.group = GRP_LITERAL;
            bus.fields.base_source_register = opc[3:0];
            bus.fields.literal = {6'h00, op[15:6]};
            bus.fields.has_dst = opc[4];
            bus.fields.dst_mode = op[5:4];
            bus.fields.result_destination_register = op[3:0];
        end else if (opc < OPC_DSP_LO) begin
            bus.fields.group = GRP_DSP;
            bus.fields.mac_form = 1'b1;
            bus.fields.acc_b = op[15];
            bus.fields.mult_pair = op[14:12];
            bus.fields.x_prefetch = op[11:8];
            bus.fields.y_prefetch = op[7:4];
            bus.fields.x_dest = op[3:2];
            bus.fields.y_dest = op[1:0];
            bus.fields.acc_writeback = opc[0];
        end else begin
            bus.fields.group = GRP_DSP;
            bus.fields.acc_b = op[15];
            bus.fields.shift_from_reg = op[14];
            bus.fields.shift_amount_register = op[13:10];
            bus.fields.literal = {12'h000, op[13:10]};
            bus.fields.dst_mode = op[5:4];
            bus.fields.result_destination_register = op[3:0];
        end
    end
endmodule : field_extract
`default_nettype wire

/* core/instruction_format_decoder.sv */
// Instruction format decoder with cycle and no-operation sequencing
// Notes on behaviour
// - Nearly all instructions are one 24-bit word
// - Top 8 bits give type, rest operands
// - Classify into six instruction groups
// - Register ops decode base, source, destination
// - File ops decode address and destination select
// - Bit ops decode target and bit position
// - Literal moves decode literal and target
// - Literal arithmetic: base, literal, optional destination
// - Multiply ops: accumulator, pair, prefetch, writeback
// - Other signal ops: accumulator, operand, shift
// - Control ops: program address, table mode
// - Double words join into 48 bits
// - Lone second word runs as no-operation
// - Taken condition or jump adds one slot
// - Branches, tables, returns take extra cycles
// - Taken skip costs two or three cycles
// - Double-word instructions take two cycles
`timescale 1ns/1ps
`default_nettype none
module instruction_format_decoder (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [decoder_pkg::WORD_W-1:0] word_in,
    input wire logic word_valid,
    input wire logic cond_true,
    output logic fetch_ready,
    output logic issue_valid,
    output logic issue_nop,
    output logic is_double,
    output logic [1:0] instr_cycles,
    output decoder_pkg::decoded_s decoded
);
    import decoder_pkg::*;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_FIRST = 2'b00,
        ST_SECOND = 2'b01,
        ST_STALL = 2'b10,
        ST_SKIP_SECOND = 2'b11
    } state_e;

    // Is the opcode the first word of a double-word instruction
    function automatic logic opc_double(input logic [7:0] o);
        opc_double = (o >= OPC_DOUBLE_LO) && (o <= OPC_DOUBLE_HI);
    endfunction : opc_double

    // Fixed extra slots of single-word control instructions
    function automatic logic [1:0] opc_extra(input logic [7:0] o);
        if (o == OPC_BRA || o == OPC_BRA_COMPUTED || o == OPC_INDIRECT) begin
            opc_extra = EXTRA_BRANCH;
        end else if (o >= OPC_TABLE_LO && o <= OPC_TABLE_HI) begin
            opc_extra = EXTRA_TABLE;
        end else if (o == OPC_RETURN || o == OPC_RET_INT) begin
            opc_extra = EXTRA_RETURN;
        end else begin
            opc_extra = EXTRA_NONE;
        end
    endfunction : opc_extra

    logic rst_meta_q;       // Reset release, first stage
    logic rst_sync_q;       // Reset release, used copy
    state_e state_q;
    state_e state_d;
    logic [1:0] stall_cnt_q;  // No-operation slots left
    logic [1:0] extra;        // Slots added by the current word
    logic skip_pend_q;        // Next instruction is skipped
    decoded_s first_q;        // Held first half of a double word
    logic [7:0] cur_opc;
    logic take;               // A word is taken this cycle

    decode_if dif ();

    // Word splitter
    field_extract u_extract (
        .bus(dif.producer)
    );

    assign cur_opc = word_in[WORD_W-1:OPC_LSB];
    assign dif.word = word_in;
    assign take = word_valid && fetch_ready;

    // Reset release through two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Extra slots for the word being taken
    always_comb begin
        extra = opc_extra(cur_opc);
        if (cur_opc >= OPC_COND_LO && cur_opc <= OPC_COND_HI && cond_true) begin
            extra = EXTRA_TAKEN;
        end
    end

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_FIRST: begin
                if (take) begin
                    if (skip_pend_q) begin
                        // skipped double word costs one more
                        state_d = opc_double(cur_opc) ? ST_SKIP_SECOND
                                                      : ST_FIRST;
                    end else if (opc_double(cur_opc)) begin
                        state_d = ST_SECOND;
                    end else if (extra != EXTRA_NONE) begin
                        state_d = ST_STALL;
                    end
                end
            end
            ST_SECOND: begin
                if (take) begin
                    state_d = ST_FIRST;
                end
            end
            ST_STALL: begin
                if (stall_cnt_q == 2'h1) begin
                    state_d = ST_FIRST;
                end
            end
            ST_SKIP_SECOND: begin
                if (take) begin
                    state_d = ST_FIRST;
                end
            end
            default: begin
                state_d = ST_FIRST;
            end
        endcase
    end

    // State and fetch handshake
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= ST_FIRST;
            fetch_ready <= 1'b0;
        end else begin
            state_q <= state_d;
            fetch_ready <= (state_d != ST_STALL);
        end
    end

    // Stall counter for inserted slots
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            stall_cnt_q <= 2'h0;
        end else if (state_q == ST_FIRST && state_d == ST_STALL) begin
            stall_cnt_q <= extra;
        end else if (state_q == ST_STALL) begin
            stall_cnt_q <= stall_cnt_q - 2'h1;
        end
    end

    // Skip request from a taken skip instruction
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            skip_pend_q <= 1'b0;
        end else if (state_q == ST_FIRST && take) begin
            skip_pend_q <= !skip_pend_q && cur_opc == OPC_SKIP && cond_true;
        end
    end

    // Hold first half of a double word
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            first_q <= '0;
        end else if (state_q == ST_FIRST && take && !skip_pend_q) begin
            first_q <= dif.fields;
        end
    end

    // Issue outputs
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            issue_valid <= 1'b0;
            issue_nop <= 1'b0;
            is_double <= 1'b0;
            instr_cycles <= 2'h0;
            decoded <= '0;
        end else begin
            issue_valid <= 1'b0;
            issue_nop <= 1'b0;
            is_double <= 1'b0;
            instr_cycles <= 2'h0;
            case (state_q)
                ST_FIRST: begin
                    if (take && skip_pend_q) begin
                        issue_nop <= 1'b1;
                    end else if (take && !opc_double(cur_opc)) begin
                        issue_valid <= 1'b1;
                        // zero top byte decodes as no-operation
                        issue_nop <= (cur_opc == OPC_NOP);
                        decoded <= dif.fields;
                        instr_cycles <= CYCLES_ONE + extra;
                    end
                end
                ST_SECOND: begin
                    if (take) begin
                        // join 48 bits into one issue
                        issue_valid <= 1'b1;
                        is_double <= 1'b1;
                        decoded <= first_q;
                        decoded.prog_addr <= {word_in[ADDR_HI_W-1:0],
                                              first_q.literal};
                        decoded.literal <= word_in[OPND_W-1:0];
                        instr_cycles <= CYCLES_DOUBLE;
                    end
                end
                ST_STALL: begin
                    issue_nop <= 1'b1;
                end
                ST_SKIP_SECOND: begin
                    issue_nop <= take;
                end
                default: begin
                    issue_nop <= 1'b0;
                end
            endcase
        end
    end
endmodule : instruction_format_decoder
`default_nettype wire

/* tb/decoder_checker.sv */
// Port-level assertions for the instruction format decoder
`timescale 1ns/1ps
`default_nettype none
module decoder_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [decoder_pkg::WORD_W-1:0] word_in,
    input wire logic word_valid,
    input wire logic cond_true,
    input wire logic fetch_ready,
    input wire logic issue_valid,
    input wire logic issue_nop,
    input wire logic is_double,
    input wire logic [1:0] instr_cycles,
    input wire decoder_pkg::decoded_s decoded
);
    import decoder_pkg::*;
    // One clock domain for every check
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Opcode of the instruction being issued
    logic [7:0] op;
    assign op = decoded.opcode;

    a_double_two_cycles: assert property (is_double |->
        issue_valid && instr_cycles == 2'h2) else $error("double not 2");
    a_wide_op_single: assert property (issue_valid && op >= 8'h10 |->
        instr_cycles == 2'h1 && !is_double) else $error("wide op cycles");
    a_lone_second_nop: assert property (issue_valid && op == 8'h00 |->
        issue_nop && instr_cycles == 2'h1) else $error("lone word not nop");
    a_branch_slot: assert property (issue_valid && op >= 8'h01 &&
        op <= 8'h03 |-> instr_cycles == 2'h2 && !fetch_ready ##1
        issue_nop && !issue_valid && fetch_ready) else $error("branch slot");
    a_table_slots: assert property (issue_valid && op >= 8'h04 &&
        op <= 8'h09 |-> instr_cycles == 2'h3 && !fetch_ready ##1
        (issue_nop && !fetch_ready) ##1 issue_nop) else $error("table slots");
    a_cond_cost: assert property (issue_valid && (op == 8'h0a ||
        op == 8'h0b) |-> instr_cycles == ($past(cond_true) ? 2'h2 : 2'h1))
        else $error("conditional cost");
    a_skip_reports_one: assert property (issue_valid &&
        op == 8'h0c |-> instr_cycles == 2'h1) else $error("skip cycles");
    a_bit_group: assert property (issue_valid && op[7:5] == 3'h3 |->
        decoded.group == GRP_BIT) else $error("bit group");
    a_double_flag_op: assert property (is_double |->
        op >= 8'h0d && op <= 8'h0f) else $error("double opcode");
    a_quiet_in_reset: assert property (disable iff (1'b0)
        !resetn |-> !issue_valid && !issue_nop && !fetch_ready)
        else $error("active in reset");
    // Double-word issue seen
    c_double: cover property (is_double);
endmodule : decoder_checker
bind instruction_format_decoder decoder_checker decoder_checker_inst (
    .clock, .resetn, .word_in, .word_valid, .cond_true, .fetch_ready,
    .issue_valid, .issue_nop, .is_double, .instr_cycles, .decoded);
`default_nettype wire

/* tb/fetch_model.sv */
// Program fetch model that offers queued words with their test result
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
    input wire logic clock,
    input wire logic fetch_ready,
    output logic [23:0] word_in,
    output logic word_valid,
    output logic cond_true
);
    logic [24:0] q[$];      // Pending {cond, word} entries
    logic [23:0] last = '0; // Last offered word
    bit slow = 0;           // Random gaps before offering
    bit taken;
    initial begin
        word_in = '0;
        word_valid = 0;
        cond_true = 0;
    end
    // words in order, held until taken
    always @(posedge clock) begin
        taken = word_valid && fetch_ready;
        #1;
        if (taken) begin
            void'(q.pop_front());
            word_valid = 0;
        end
        // Offer next word, or show a changed idle value
        if (!word_valid) begin
            if (q.size() > 0 && !(slow && $urandom_range(0, 2) == 0)) begin
                {cond_true, word_in} = q[0];
                last = q[0][23:0];
                word_valid = 1;
            end else begin
                word_in = ~last;
                cond_true = ~cond_true;
            end
        end
    end
endmodule : fetch_model
`default_nettype wire

/* tb/test_instruction_format_decoder.sv */
// Self-checking bench for the instruction format decoder
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        fail_count++; \
        $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); \
    end \
end
module test_instruction_format_decoder;
    import decoder_pkg::*;
    // Expected issue record
    typedef struct {
        logic vld; logic nop; logic dbl; logic [1:0] cyc;
        logic [7:0] op; logic [22:0] pa; logic [15:0] lit;
    } exp_s;
    logic clock, resetn, word_valid, cond_true, fetch_ready;
    logic issue_valid, issue_nop, is_double;
    logic [WORD_W-1:0] word_in;
    logic [1:0] instr_cycles;
    decoded_s decoded;
    int fail_count = 0;
    int samples_checked = 0;
    exp_s exp_q[$];
    int skip_st = 0;        // 1 skip next word, 2 skip its second word
    bit have_first = 0;     // First word of a double seen
    logic [23:0] first_w;
    int i;

    instruction_format_decoder instruction_format_decoder_inst (
        .clock, .resetn, .word_in, .word_valid, .cond_true, .fetch_ready,
        .issue_valid, .issue_nop, .is_double, .instr_cycles, .decoded);
    fetch_model fetch_model_inst (
        .clock, .fetch_ready, .word_in, .word_valid, .cond_true);

    always #5 clock = ~clock;

    function automatic group_e grp(input logic [7:0] op);
        if (op < 8'h10) return GRP_CONTROL;
        if (op < 8'h60) return GRP_WORD_BYTE;
        if (op < 8'h80) return GRP_BIT;
        if (op < 8'hc0) return GRP_LITERAL;
        return GRP_DSP;
    endfunction : grp

    task automatic slot();
        exp_s e;
        e = '{1'b0, 1'b1, 1'b0, 2'h0, 8'h00, 23'h0, 16'h0};
        exp_q.push_back(e);
    endtask : slot

    // Queue a word and note what it must produce
    task automatic send(input logic [23:0] w, input logic c);
        exp_s e;
        logic [7:0] op;
        logic [1:0] extra;
        op = w[23:16];
        fetch_model_inst.q.push_back({c, w});
        if (skip_st != 0) begin
            slot();
            skip_st = (skip_st == 1 && op >= 8'h0d && op <= 8'h0f) ? 2 : 0;
        end else if (have_first) begin
            e = '{1'b1, 1'b0, 1'b1, 2'h2, first_w[23:16],
                  {w[6:0], first_w[15:0]}, w[15:0]};
            exp_q.push_back(e);
            have_first = 0;
        end else if (op >= 8'h0d && op <= 8'h0f) begin
            have_first = 1;
            first_w = w;
        end else begin
            extra = 2'h0;
            if (op >= 8'h01 && op <= 8'h03) extra = 2'h1;
            if (op >= 8'h04 && op <= 8'h09) extra = 2'h2;
            if ((op == 8'h0a || op == 8'h0b) && c) extra = 2'h1;
            e = '{1'b1, op == 8'h00, 1'b0, extra + 2'h1, op, 23'h0, w[15:0]};
            exp_q.push_back(e);
            repeat (extra) slot();
            if (op == 8'h0c && c) skip_st = 1;
        end
    endtask : send

    // One instruction with random operand and test result
    task automatic instr(input logic [7:0] op);
        send({op, 16'($urandom)}, 1'($urandom_range(0, 1)));
        if (op >= 8'h0d && op <= 8'h0f) send({8'h00, 16'($urandom)}, 1'b0);
    endtask : instr

    task automatic drain(input string name);
        int n;
        for (n = 0; n < 20000; n++) begin
            @(posedge clock);
            if (exp_q.size() == 0 && fetch_model_inst.q.size() == 0) break;
        end
        if (n == 20000) fail_count++;
        $display("test %s done", name);
    endtask : drain

    // Pull reset low off the edge, hold it n edges, wait for fetch_ready
    task automatic restart(input int n);
        #1 resetn = 0;
        repeat (n) @(posedge clock);
        #1 resetn = 1;
        for (i = 0; i < 20 && fetch_ready !== 1'b1; i++) @(posedge clock);
    endtask : restart

    task automatic summarize();
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    // Compare each issue or slot with the oldest note
    always @(negedge clock) begin
        exp_s e;
        if (resetn === 1'b1 && (issue_valid | issue_nop) === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHECK(issue_nop, 1'bz)
            end else begin
                e = exp_q.pop_front();
                `CHECK(issue_nop, e.nop)
                `CHECK(issue_valid, e.vld)
                if (e.vld) begin
                    `CHECK(instr_cycles, e.cyc)
                    `CHECK(is_double, e.dbl)
                    `CHECK(decoded.opcode, e.op)
                    if (e.op != 8'h00)
                        `CHECK(decoded.group, grp(e.op))
                    if (!e.dbl && e.op < 8'ha0)
                        `CHECK(decoded.literal, e.lit)
                    `CHECK(decoded.mac_form, e.op[7:5] == 3'h6)
                    if (e.op[7:5] == 3'h2)
                        `CHECK(decoded.file_form, 1'b1)
                    if (e.dbl) `CHECK(decoded.prog_addr, e.pa)
                    if (e.dbl) `CHECK(decoded.literal, e.lit)
                end
            end
        end
    end

    // Watchdog on a hang
    initial begin
        #400000;
        fail_count++;
        summarize();
    end

    initial begin
        clock = 0;
        resetn = 1;
        void'($urandom(32'h17a943d9));
        // Falling reset edge before the first clock edge
        restart(12);
        // Every opcode once, back to back
        for (i = 0; i < 256; i++) instr(i[7:0]);
        drain("sweep");
        // skip over single and double words
        send({8'h0c, 16'h1234}, 1'b1);
        send({8'h44, 16'h0000}, 1'b0);
        send({8'h0c, 16'h0000}, 1'b1);
        send({8'h0e, 16'h0005}, 1'b0);
        send({8'h00, 16'h007f}, 1'b0);
        send({8'h0c, 16'h0000}, 1'b0);
        send({8'h20, 16'h0000}, 1'b0);
        // lone second word, conditions both ways
        send({8'h00, 16'h003c}, 1'b0);
        send({8'h0a, 16'h0000}, 1'b1);
        send({8'h0b, 16'h0000}, 1'b0);
        instr(8'h0f);
        instr(8'h0d);
        drain("skip");
        // Reset again in mid-run, queues already empty
        restart(3);
        // Random words with a hesitant fetch side
        fetch_model_inst.slow = 1;
        for (i = 0; i < 300; i++) instr(8'($urandom));
        drain("slow");
        summarize();
    end
endmodule : test_instruction_format_decoder
`default_nettype wire
